/* design/osd_act_mon.sv */
// Activity monitor: watches the sampled main oscillator level for edges.
// Assumes the level is synchronous to clk and a tick enable from a divider.
`timescale 1ns/1ps
module osd_act_mon #(
	parameter int LIMIT = osd_pkg::STOP_TICKS
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic tick,
	input  wire logic osc_level,
	output logic      alive
);

	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);

	logic          prev_q;
	logic [CW-1:0] idle_q;

	// Ticks without an edge, saturating at the limit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= 1'b0;
			idle_q <= LIM;
			alive  <= 1'b0;
		end else begin
			prev_q <= osc_level;
			if (osc_level != prev_q) begin
				idle_q <= '0;
			end else if (tick && idle_q != LIM) begin
				idle_q <= idle_q + 1'b1;
			end
			alive <= (idle_q != LIM) || (osc_level != prev_q);
		end
	end

endmodule : osd_act_mon

/* design/osd_pkg.sv */
// Package for the oscillation stop and re-oscillation detector.
// Assumes one 10 MHz clock and a plain register port with 8-bit data.
// Functional notes
// - The detector's interrupt leaves on the same line as the watchdog interrupt.
// - The detection flag is set in the same cycle as a stop or re-oscillation interrupt.
// - While the detection flag is set no further stop or re-oscillation interrupt is raised.
// - Software clears the detection flag, after which detection interrupts are allowed again.
// - A main clock stop in low speed mode with detection enabled raises a stop interrupt.
// - With that stop interrupt the on-chip oscillator is started.
// - After such a stop the CPU stays on the sub clock and peripherals move to the on-chip oscillator.
// - Detection enable at 0 disables detection; software clears it before halting the main clock.
package osd_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;

	// Control register fields
	localparam int CTRL_EN          = 0;
	localparam int CTRL_WAIT_GATE   = 1;
	localparam int CTRL_MAIN_HALT   = 2;
	localparam int CTRL_PERIPH_MAIN = 3;

	// Status register fields; bits 0..2 are sticky and cleared by writing 1
	localparam int STAT_FLAG       = 0;
	localparam int STAT_STOP       = 1;
	localparam int STAT_REOSC      = 2;
	localparam int STAT_OCO_RUN    = 3;
	localparam int STAT_ALIVE      = 4;
	localparam int STAT_PERIPH_OCO = 5;
	localparam int EVT_W           = 3;

	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [EVT_W-1:0]  MASK_RESET = 3'h0;

	// Timing: a tick every microsecond, main clock judged stopped after 2 us without an edge
	localparam longint CLK_HZ          = 10_000_000;
	localparam longint TICK_NS         = 1000;
	localparam longint STOP_TIMEOUT_NS = 2000;
	localparam int TICK_CYC  = int'((TICK_NS * CLK_HZ) / 1_000_000_000);
	localparam int STOP_TICKS = int'(STOP_TIMEOUT_NS / TICK_NS);

	typedef enum logic [0:0] {
		OSD_MODE_MAIN = 1'b0,
		OSD_MODE_OCO  = 1'b1
	} osd_mode_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} osd_bus_req_t;

	typedef struct packed {
		logic              en;
		logic              wait_gate;
		logic              main_halt;
		osd_mode_t         mode;
		logic [EVT_W-1:0]  stat;
		logic [EVT_W-1:0]  mask;
		logic              alive_prev;
		logic              oco_run;
		logic              cpu_sub;
		logic              irq;
		logic              shared_irq;
		logic [DATA_W-1:0] rdata;
	} osd_state_t;

endpackage : osd_pkg

/* design/osd_tick_div.sv */
// Divider giving a one-cycle tick enable at a slower rate.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module osd_tick_div #(
	parameter int DIV = osd_pkg::TICK_CYC
) (
	input  wire logic clk,
	input  wire logic arst_n,
	output logic      tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			tick  <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
		end
	end

endmodule : osd_tick_div

/* design/osd_top.sv */
// Oscillation stop and re-oscillation detector with register port.
// Assumes MCLK at 10 MHz, main oscillator level sampled synchronously,
// register master with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
module osd_top (
	input  wire logic                        MCLK,
	input  wire logic                        ARST_N,
	input  wire logic [osd_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [osd_pkg::DATA_W-1:0]  WDATA,
	input  wire logic                        WR,
	input  wire logic                        RD,
	output logic      [osd_pkg::DATA_W-1:0]  RDATA,
	input  wire logic                        MAIN_OSC,
	input  wire logic                        LOW_SPEED,
	input  wire logic                        WDT_IRQ,
	output logic                             IRQ,
	output logic                             SHARED_IRQ,
	output logic                             OCO_RUN,
	output logic                             PERIPH_CLK_OCO,
	output logic                             CPU_CLK_SUB,
	output logic                             WAIT_PERIPH_GATE,
	output logic                             MAIN_HALT
);

	osd_pkg::osd_state_t   s_q;
	osd_pkg::osd_state_t   s_d;
	osd_pkg::osd_bus_req_t req;
	logic                  tick;
	logic                  alive;
	logic                  wr_ctrl;
	logic                  wr_stat;
	logic                  wr_mask;
	logic                  rd_ctrl;
	logic                  rd_stat;
	logic                  rd_mask;
	logic                  detect_on;
	logic                  stop_evt;
	logic                  reosc_evt;
	logic [osd_pkg::EVT_W-1:0] set_bits;
	logic [osd_pkg::EVT_W-1:0] clr_bits;
	logic [osd_pkg::EVT_W-1:0] stat_next;

	// Address match, shared by the read and write decoders
	function automatic logic reg_hit(
		input logic [osd_pkg::ADDR_W-1:0] addr,
		input logic [osd_pkg::ADDR_W-1:0] off
	);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// One assignment keeps a single driver on the request struct
	assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

	osd_tick_div #(
		.DIV (osd_pkg::TICK_CYC)
	) u_div (
		.clk    (MCLK),
		.arst_n (ARST_N),
		.tick   (tick)
	);

	osd_act_mon #(
		.LIMIT (osd_pkg::STOP_TICKS)
	) u_mon (
		.clk       (MCLK),
		.arst_n    (ARST_N),
		.tick      (tick),
		.osc_level (MAIN_OSC),
		.alive     (alive)
	);

	assign wr_ctrl = req.wr && reg_hit(req.addr, osd_pkg::OFF_CTRL);
	assign wr_stat = req.wr && reg_hit(req.addr, osd_pkg::OFF_STAT);
	assign wr_mask = req.wr && reg_hit(req.addr, osd_pkg::OFF_MASK);
	assign rd_ctrl = req.rd && reg_hit(req.addr, osd_pkg::OFF_CTRL);
	assign rd_stat = req.rd && reg_hit(req.addr, osd_pkg::OFF_STAT);
	assign rd_mask = req.rd && reg_hit(req.addr, osd_pkg::OFF_MASK);

	// Detection runs only while enabled and no earlier event is pending
	assign detect_on = s_q.en && !s_q.stat[osd_pkg::STAT_FLAG];

	// Stop: the main clock falls silent in low speed mode
	assign stop_evt = detect_on && LOW_SPEED && s_q.alive_prev && !alive;

	// Re-oscillation: edges return while peripherals run from the on-chip oscillator
	assign reosc_evt = detect_on && (s_q.mode == osd_pkg::OSD_MODE_OCO)
		&& !s_q.alive_prev && alive;

	always_comb begin
		set_bits = '0;
		set_bits[osd_pkg::STAT_FLAG]  = stop_evt || reosc_evt;
		set_bits[osd_pkg::STAT_STOP]  = stop_evt;
		set_bits[osd_pkg::STAT_REOSC] = reosc_evt;
	end

	assign clr_bits  = wr_stat ? req.wdata[osd_pkg::EVT_W-1:0] : '0;
	// A set in the same cycle as a clear wins
	assign stat_next = (s_q.stat & ~clr_bits) | set_bits;

	always_comb begin
		s_d = s_q;
		s_d.alive_prev = alive;
		s_d.cpu_sub    = LOW_SPEED;
		s_d.stat       = stat_next;

		if (wr_ctrl) begin
			s_d.en        = req.wdata[osd_pkg::CTRL_EN];
			s_d.wait_gate = req.wdata[osd_pkg::CTRL_WAIT_GATE];
			s_d.main_halt = req.wdata[osd_pkg::CTRL_MAIN_HALT];
		end
		if (wr_mask) begin
			s_d.mask = req.wdata[osd_pkg::EVT_W-1:0];
		end

		case (s_q.mode)
			osd_pkg::OSD_MODE_MAIN: begin
				if (stop_evt) begin
					s_d.mode    = osd_pkg::OSD_MODE_OCO;
					s_d.oco_run = 1'b1;
				end
			end
			osd_pkg::OSD_MODE_OCO: begin
				// Only software returns the peripherals to the main clock
				if (wr_ctrl && req.wdata[osd_pkg::CTRL_PERIPH_MAIN]) begin
					s_d.mode    = osd_pkg::OSD_MODE_MAIN;
					s_d.oco_run = 1'b0;
				end
			end
			default: begin
				s_d.mode    = osd_pkg::OSD_MODE_MAIN;
				s_d.oco_run = 1'b0;
			end
		endcase

		s_d.irq        = |(stat_next & s_d.mask);
		// Detector and watchdog share one request line
		s_d.shared_irq = s_d.irq || WDT_IRQ;

		s_d.rdata = '0;
		if (rd_ctrl) begin
			s_d.rdata[osd_pkg::CTRL_EN]        = s_q.en;
			s_d.rdata[osd_pkg::CTRL_WAIT_GATE] = s_q.wait_gate;
			s_d.rdata[osd_pkg::CTRL_MAIN_HALT] = s_q.main_halt;
		end else if (rd_stat) begin
			s_d.rdata[osd_pkg::EVT_W-1:0]       = s_q.stat;
			s_d.rdata[osd_pkg::STAT_OCO_RUN]    = s_q.oco_run;
			s_d.rdata[osd_pkg::STAT_ALIVE]      = s_q.alive_prev;
			s_d.rdata[osd_pkg::STAT_PERIPH_OCO] = (s_q.mode == osd_pkg::OSD_MODE_OCO);
		end else if (rd_mask) begin
			s_d.rdata[osd_pkg::EVT_W-1:0] = s_q.mask;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_q.en         <= osd_pkg::CTRL_RESET[osd_pkg::CTRL_EN];
			s_q.wait_gate  <= osd_pkg::CTRL_RESET[osd_pkg::CTRL_WAIT_GATE];
			s_q.main_halt  <= osd_pkg::CTRL_RESET[osd_pkg::CTRL_MAIN_HALT];
			s_q.mode       <= osd_pkg::OSD_MODE_MAIN;
			s_q.stat       <= '0;
			s_q.mask       <= osd_pkg::MASK_RESET;
			s_q.alive_prev <= 1'b0;
			s_q.oco_run    <= 1'b0;
			s_q.cpu_sub    <= 1'b0;
			s_q.irq        <= 1'b0;
			s_q.shared_irq <= 1'b0;
			s_q.rdata      <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA            = s_q.rdata;
	assign IRQ              = s_q.irq;
	assign SHARED_IRQ       = s_q.shared_irq;
	assign OCO_RUN          = s_q.oco_run;
	assign PERIPH_CLK_OCO   = (s_q.mode == osd_pkg::OSD_MODE_OCO);
	assign CPU_CLK_SUB      = s_q.cpu_sub;
	assign WAIT_PERIPH_GATE = s_q.wait_gate;
	assign MAIN_HALT        = s_q.main_halt;

endmodule : osd_top

/* test/osd_osc_model.sv */
// Main oscillator model: toggles its sampled level every cycle while running.
// Assumes a stopped crystal freezes at its last level.
`timescale 1ns/1ps
module osd_osc_model (
	input  wire logic clk,
	input  wire logic run,
	output logic      osc
);
	initial osc = 1'b0;
	always @(posedge clk)
		if (run)
			osc <= ~osc;
endmodule : osd_osc_model

/* test/osd_properties.sv */
// Port checker for the oscillation stop detector.
// Assumes it is bound to osd_top and sees only that module's ports.
`timescale 1ns/1ps
module osd_properties (
	input wire logic                       MCLK,
	input wire logic                       ARST_N,
	input wire logic [osd_pkg::ADDR_W-1:0] ADDR,
	input wire logic [osd_pkg::DATA_W-1:0] WDATA,
	input wire logic                       WR,
	input wire logic                       RD,
	input wire logic [osd_pkg::DATA_W-1:0] RDATA,
	input wire logic                       LOW_SPEED,
	input wire logic                       WDT_IRQ,
	input wire logic                       IRQ,
	input wire logic                       SHARED_IRQ,
	input wire logic                       OCO_RUN,
	input wire logic                       PERIPH_CLK_OCO,
	input wire logic                       CPU_CLK_SUB,
	input wire logic                       WAIT_PERIPH_GATE,
	input wire logic                       MAIN_HALT
);
	logic en_q;
	// Shadow of the detection enable, taken from control writes
	always_ff @(posedge MCLK or negedge ARST_N)
		if (!ARST_N)
			en_q <= 1'b0;
		else if (WR && ADDR == osd_pkg::OFF_CTRL)
			en_q <= WDATA[osd_pkg::CTRL_EN];
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	sequence s_ctrl_wr; WR && ADDR == osd_pkg::OFF_CTRL; endsequence
	sequence s_ret_wr; s_ctrl_wr ##0 WDATA[osd_pkg::CTRL_PERIPH_MAIN]; endsequence
	property p_shared; SHARED_IRQ == (IRQ || $past(WDT_IRQ)); endproperty
	property p_cpu_sub; CPU_CLK_SUB == $past(LOW_SPEED); endproperty
	property p_oco_start;
		$rose(PERIPH_CLK_OCO) |-> OCO_RUN && $past(LOW_SPEED) && $past(en_q);
	endproperty
	property p_oco_pair; PERIPH_CLK_OCO |-> OCO_RUN; endproperty
	property p_hold;
		PERIPH_CLK_OCO && !(WR && ADDR == osd_pkg::OFF_CTRL
			&& WDATA[osd_pkg::CTRL_PERIPH_MAIN]) |=> PERIPH_CLK_OCO;
	endproperty
	property p_ret; s_ret_wr |=> !PERIPH_CLK_OCO && !OCO_RUN; endproperty
	property p_ctrl_out;
		s_ctrl_wr |=> WAIT_PERIPH_GATE == $past(WDATA[osd_pkg::CTRL_WAIT_GATE])
			&& MAIN_HALT == $past(WDATA[osd_pkg::CTRL_MAIN_HALT]);
	endproperty
	property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
	a_shared: assert property (p_shared) else $error("shared line wrong");
	a_cpu_sub: assert property (p_cpu_sub) else $error("cpu clock moved");
	a_oco_start: assert property (p_oco_start) else $error("bad stop switch");
	a_oco_pair: assert property (p_oco_pair) else $error("oscillator off");
	a_hold: assert property (p_hold) else $error("peripherals left oscillator");
	a_ret: assert property (p_ret) else $error("return ignored");
	a_ctrl_out: assert property (p_ctrl_out) else $error("control bits wrong");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : osd_properties

/* test/tb_oscillation_stop_detect.sv */
// Scoreboard bench for the oscillation stop detector.
// Assumes osd_top with its default ten-cycle tick divider and two-tick stop timeout.
`timescale 1ns/1ps
module tb_oscillation_stop_detect;
	logic       MCLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, LOW_SPEED = 1'b0;
	logic       WDT_IRQ = 1'b0, run = 1'b0, pend = 1'b0, MAIN_OSC;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, lfsr = 8'h18, d;
	logic       IRQ, SHARED_IRQ, OCO_RUN, PERIPH_CLK_OCO, CPU_CLK_SUB, WAIT_PERIPH_GATE, MAIN_HALT;
	logic [7:0] exp_q[$];
	int         fail_count = 0, n_tests = 0;
	// Output vector: irq, shared, oco, periph, cpu, gate, halt
	wire  [7:0] outs = {1'b0, IRQ, SHARED_IRQ, OCO_RUN, PERIPH_CLK_OCO, CPU_CLK_SUB,
		WAIT_PERIPH_GATE, MAIN_HALT};
	always #50 MCLK = ~MCLK;
	osd_osc_model osc (.clk(MCLK), .run(run), .osc(MAIN_OSC));
	osd_top dut (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .MAIN_OSC(MAIN_OSC), .LOW_SPEED(LOW_SPEED), .WDT_IRQ(WDT_IRQ), .IRQ(IRQ),
		.SHARED_IRQ(SHARED_IRQ), .OCO_RUN(OCO_RUN), .PERIPH_CLK_OCO(PERIPH_CLK_OCO),
		.CPU_CLK_SUB(CPU_CLK_SUB), .WAIT_PERIPH_GATE(WAIT_PERIPH_GATE), .MAIN_HALT(MAIN_HALT));
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nxt
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= v;
		WR <= w;
		RD <= !w;
		@(posedge MCLK);
		WR <= 1'b0;
		RD <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(negedge MCLK);
	endtask : idle
	task automatic wait_irq;
		int i;
		for (i = 0; i < 200 && IRQ !== 1'b1; i++)
			@(negedge MCLK);
		if (IRQ !== 1'b1) begin
			fail_count++;
			give_verdict;
		end
	endtask : wait_irq
	// Read data is due in the cycle after the strobe only
	always @(negedge MCLK) begin
		if (pend)
			chk(RDATA, exp_q.pop_front());
		pend = RD;
	end
	initial begin
		repeat (16) @(posedge MCLK);
		ARST_N <= 1'b1;
		rd(osd_pkg::OFF_CTRL, osd_pkg::CTRL_RESET);
		rd(osd_pkg::OFF_STAT, 8'h00);
		rd(osd_pkg::OFF_MASK, {5'h00, osd_pkg::MASK_RESET});
		lfsr = nxt(lfsr);
		d = (lfsr >> 3) & 8'h06;
		bus(1'b1, 8'h0C, lfsr);
		bus(1'b1, osd_pkg::OFF_CTRL, d);
		rd(8'h0C, 8'h00);
		rd(osd_pkg::OFF_CTRL, d);
		run <= 1'b1;
		LOW_SPEED <= 1'b1;
		idle(10);
		chk(outs, {1'b0, 5'h01, d[1], d[2]});
		@(posedge MCLK) run <= 1'b0;
		idle(60);
		chk(outs, {1'b0, 5'h01, d[1], d[2]});
		rd(osd_pkg::OFF_STAT, 8'h00);
		run <= 1'b1;
		bus(1'b1, osd_pkg::OFF_MASK, 8'h07);
		bus(1'b1, osd_pkg::OFF_CTRL, 8'h01);
		idle(10);
		@(posedge MCLK) run <= 1'b0;
		wait_irq();
		chk(outs, 8'h7C);
		rd(osd_pkg::OFF_STAT, 8'h2B);
		run <= 1'b1;
		idle(20);
		chk(outs, 8'h7C);
		rd(osd_pkg::OFF_STAT, 8'h3B);
		bus(1'b1, osd_pkg::OFF_STAT, 8'h07);
		idle(2);
		chk(outs, 8'h1C);
		rd(osd_pkg::OFF_STAT, 8'h38);
		run <= 1'b0;
		wait_irq();
		rd(osd_pkg::OFF_STAT, 8'h2B);
		bus(1'b1, osd_pkg::OFF_STAT, 8'h07);
		run <= 1'b1;
		idle(2);
		wait_irq();
		rd(osd_pkg::OFF_STAT, 8'h3D);
		bus(1'b1, osd_pkg::OFF_MASK, 8'h00);
		idle(2);
		chk(outs, 8'h1C);
		@(posedge MCLK) WDT_IRQ <= 1'b1;
		idle(2);
		chk(outs, 8'h3C);
		@(posedge MCLK) WDT_IRQ <= 1'b0;
		bus(1'b1, osd_pkg::OFF_MASK, 8'h07);
		idle(2);
		chk(outs, 8'h7C);
		bus(1'b1, osd_pkg::OFF_CTRL, 8'h09);
		idle(2);
		chk(outs, 8'h64);
		rd(osd_pkg::OFF_CTRL, 8'h01);
		bus(1'b1, osd_pkg::OFF_STAT, 8'h07);
		idle(2);
		chk(outs, 8'h04);
		give_verdict();
	end
endmodule : tb_oscillation_stop_detect
bind osd_top osd_properties u_prop (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .LOW_SPEED(LOW_SPEED), .WDT_IRQ(WDT_IRQ), .IRQ(IRQ),
	.SHARED_IRQ(SHARED_IRQ), .OCO_RUN(OCO_RUN), .PERIPH_CLK_OCO(PERIPH_CLK_OCO),
	.CPU_CLK_SUB(CPU_CLK_SUB), .WAIT_PERIPH_GATE(WAIT_PERIPH_GATE), .MAIN_HALT(MAIN_HALT));
